// File: inc/total_config_consts.svh
// Purpose: named offsets, word indices, field positions and reset values of the total-configuration job handler
// Assumes: APB byte addresses on an 8-bit address bus, 16-bit job words
// Notes: definitions only
`ifndef TOTAL_CONFIG_CONSTS_SVH
`define TOTAL_CONFIG_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_JOB_DATA 8'h00
`define OFS_JOB_CTRL 8'h04
`define OFS_STATUS 8'h08
`define OFS_RESP_DATA 8'h0c
`define OFS_MODE 8'h10

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define CTRL_START_BIT 0
`define CTRL_CLEAR_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_ERROR_BIT 2
`define STAT_CFGMODE_BIT 3
`define STAT_JOBCNT_LSB 8
`define STAT_RESPLEFT_LSB 16
`define MODE_CFGSEL_BIT 0
`define MODE_AUTOADDR_BIT 1

// ----------------------------------------------------------------
// job word layout
// ----------------------------------------------------------------
`define CMD_GROUP 4'h1
`define CMD_READ_TOTAL 4'h9
`define CMD_CONFIG_TOTAL 4'ha
`define READ_JOB_LEN 5'd1
`define CONFIG_JOB_LEN 5'd28
`define JOB_DEPTH 28
`define JOB_CNT_MAX 5'h1f
`define JOB_LIST_FIRST 5'd1
`define JOB_CFG_FIRST 5'd3
`define JOB_PARAM_FIRST 5'd19
`define JOB_FLAG_WORD 5'd27

// ----------------------------------------------------------------
// response word layout
// ----------------------------------------------------------------
`define RESP_LEN 5'd27
`define RESP_CFG_FIRST 5'd2
`define RESP_PARAM_FIRST 5'd18
`define RESP_FLAG_WORD 5'd26

// ----------------------------------------------------------------
// flag positions inside the 16-bit flag word
// ----------------------------------------------------------------
`define FLAGW_CFG_MODE_BIT 11
`define FLAGW_AUTO_ADDR_BIT 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CONFIG_MODE 1'b1
`define RST_CFG_MODE_SEL 1'b1
`define RST_AUTO_ADDR 1'b0

`endif

// File: inc/total_config_pkg.sv
// Purpose: types shared by the total-configuration job handler and its bench
// Assumes: 32 slaves, one byte of configuration and one nibble of parameter per slave
// Notes: constants live in total_config_consts.svh
package total_config_pkg;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_LOAD = 1'b1
	} exec_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} apb_rsp_t;

	// live view of the bus, from the bus sequencer on the same clock
	typedef struct packed {
		logic [31:0] activeSlaveList;
		logic [31:0] detectedList;
		logic [255:0] slaveCfg;
		logic [127:0] slaveParam;
		logic offlineActive;
		logic lowBusVoltage;
		logic normalMode;
		logic autoprogPossible;
		logic noWrongSlave;
		logic zeroAddressPresent;
		logic offlineRequested;
		logic eepromOk;
	} actual_cfg_t;

	typedef struct packed {
		logic [31:0] projectedSlaveList;
		logic [255:0] slaveCfg;
		logic [127:0] slaveParam;
		logic configModeSel;
		logic autoAddrEn;
	} desired_cfg_t;

	typedef struct packed {
		exec_state_t fsm;
		logic [4:0] jobWordCount;
		logic [4:0] loadIdx;
		logic [4:0] respPtr;
		logic [4:0] respLen;
		logic busy;
		logic done;
		logic error;
		logic configMode;
		logic nvStore;
		logic paramSend;
		desired_cfg_t desired;
		logic [31:0] prdata;
		logic pslverr;
	} handler_state_t;

endpackage : total_config_pkg

// File: design/job_word_store.sv
// Purpose: holds the words of one host job until it is executed
// Assumes: one write port, one asynchronous read port
// Notes: no reset; contents are only read below the written word count
`timescale 1ns/1ps
`include "total_config_consts.svh"
module job_word_store #(
	parameter int DEPTH = `JOB_DEPTH,
	parameter int WIDTH = 16,
	parameter int AW = 5
) (
	input wire logic sys_clk,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge sys_clk) begin
		if (wrEn && (int'(wrAddr) < DEPTH)) begin
			mem[wrAddr] <= wrData;
		end
	end

	assign rdData = (int'(rdAddr) < DEPTH) ? mem[rdAddr] : '0;
endmodule : job_word_store

// File: design/total_config_job_handler.sv
// Purpose: executes the read-total-configuration and configure-total-system host jobs
// Assumes: host fills the job over APB, starts it, then pops the response words
// Notes: actual bus view arrives on the same clock from the bus sequencer
`timescale 1ns/1ps
`include "total_config_consts.svh"

// Behaviour
// - read job: word nibbles 1 then 9
// - active list, two words, slave 0 at bit15
// - sixteen config words, even slave upper byte
// - eight parameter words, slave 0 slot empty
// - flag1 bits 0..7 fixed meanings
// - flag2: offline, memory ok, auto address
// - configure job: 28 words, command 1 A
// - accepted configure job replaces desired set
// - protected mode activates projected slaves only
// - stored bytes give required slave config
// - store parameters, send them at start-up
// - supplied mode flag picks mode after sync
// - supplied auto-address flag enables programming
// - all other supplied flags ignored
// - mode flag mirrors configuration mode
// - match flag only when projected list and projected slaves' config bytes equal actual
module total_config_job_handler #(
	parameter int JOB_DEPTH = `JOB_DEPTH
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input total_config_pkg::apb_req_t apbReq,
	output total_config_pkg::apb_rsp_t apbRsp,
	input total_config_pkg::actual_cfg_t actual,
	input wire logic syncDone,
	output total_config_pkg::desired_cfg_t desired,
	output logic configModeActive,
	output logic [31:0] activateMask,
	output logic nvStore,
	output logic paramSend
);

	// ----------------------------------------------------------------
	// word packing helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] list_word(input logic [31:0] list, input logic upper);
		logic [15:0] r;
		r = '0;
		for (int k = 0; k < 16; k++) begin
			r[15-k] = upper ? list[16+k] : list[k];
		end
		return r;
	endfunction : list_word

	function automatic logic [15:0] cfg_word(input logic [255:0] cfg, input logic [3:0] w);
		int s;
		s = 2 * int'(w);
		return {cfg[8*s +: 8], cfg[8*(s+1) +: 8]};
	endfunction : cfg_word

	function automatic logic [15:0] param_word(input logic [127:0] prm, input logic [2:0] w);
		logic [15:0] r;
		int s;
		r = '0;
		for (int n = 0; n < 4; n++) begin
			s = 4 * int'(w) + n;
			if (s != 0) begin
				r[15-4*n -: 4] = prm[4*s +: 4];
			end
		end
		return r;
	endfunction : param_word

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	total_config_pkg::handler_state_t st;
	total_config_pkg::handler_state_t next_st;

	logic [15:0] jobWord;
	logic [4:0] storeRdAddr;
	logic storeWrEn;
	logic configMatch;
	logic [7:0] flag1;
	logic [7:0] flag2;
	logic [15:0] respWord;
	logic setup;
	logic access;

	// ----------------------------------------------------------------
	// job word store
	// ----------------------------------------------------------------
	assign storeRdAddr = (st.fsm == total_config_pkg::ST_LOAD) ? st.loadIdx : '0;

	job_word_store #(
		.DEPTH(JOB_DEPTH),
		.WIDTH(16),
		.AW(5)
	) u_store (
		.sys_clk(sys_clk),
		.wrEn(storeWrEn),
		.wrAddr(st.jobWordCount),
		.wrData(apbReq.pwdata[15:0]),
		.rdAddr(storeRdAddr),
		.rdData(jobWord)
	);

	// ----------------------------------------------------------------
	// flags and configuration match
	// ----------------------------------------------------------------
	always_comb begin
		configMatch = (st.desired.projectedSlaveList == actual.detectedList);
		for (int s = 0; s < 32; s++) begin
			if (st.desired.projectedSlaveList[s] &&
				(st.desired.slaveCfg[8*s +: 8] != actual.slaveCfg[8*s +: 8])) begin
				configMatch = 1'b0;
			end
		end
	end

	assign flag1 = {configMatch, actual.zeroAddressPresent, st.desired.autoAddrEn & actual.noWrongSlave,
		actual.autoprogPossible, st.configMode, actual.normalMode, actual.lowBusVoltage,
		actual.offlineActive};
	// reserved bits read as zero
	assign flag2 = {4'h0, st.desired.autoAddrEn, actual.eepromOk, 1'b0, actual.offlineRequested};

	// ----------------------------------------------------------------
	// response word selection, built live from the current bus view
	// ----------------------------------------------------------------
	always_comb begin
		respWord = '0;
		if (st.respPtr < `RESP_CFG_FIRST) begin
			respWord = list_word(actual.activeSlaveList, st.respPtr[0]);
		end else if (st.respPtr < `RESP_PARAM_FIRST) begin
			respWord = cfg_word(actual.slaveCfg, 4'(st.respPtr - `RESP_CFG_FIRST));
		end else if (st.respPtr < `RESP_FLAG_WORD) begin
			respWord = param_word(actual.slaveParam, 3'(st.respPtr - `RESP_PARAM_FIRST));
		end else if (st.respPtr == `RESP_FLAG_WORD) begin
			respWord = {flag1, flag2};
		end
	end

	// ----------------------------------------------------------------
	// bus phases
	// ----------------------------------------------------------------
	assign setup = apbReq.psel & ~apbReq.penable;
	assign access = apbReq.psel & apbReq.penable;
	// job words land in the store only while idle and below its depth
	assign storeWrEn = access && apbReq.pwrite && (apbReq.paddr == `OFS_JOB_DATA) && !st.busy
		&& (int'(st.jobWordCount) < JOB_DEPTH);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		int w;
		int s;
		w = 0;
		s = 0;
		next_st = st;
		next_st.nvStore = 1'b0;
		next_st.paramSend = 1'b0;

		// read data is fetched in the setup cycle so the access cycle needs no wait
		if (setup) begin
			next_st.prdata = '0;
			next_st.pslverr = 1'b0;
			unique case (apbReq.paddr)
				`OFS_JOB_DATA, `OFS_JOB_CTRL: begin
					next_st.pslverr = !apbReq.pwrite;
				end
				`OFS_STATUS: begin
					next_st.pslverr = apbReq.pwrite;
					next_st.prdata[`STAT_BUSY_BIT] = st.busy;
					next_st.prdata[`STAT_DONE_BIT] = st.done;
					next_st.prdata[`STAT_ERROR_BIT] = st.error;
					next_st.prdata[`STAT_CFGMODE_BIT] = st.configMode;
					next_st.prdata[`STAT_JOBCNT_LSB +: 5] = st.jobWordCount;
					next_st.prdata[`STAT_RESPLEFT_LSB +: 5] = st.respLen - st.respPtr;
				end
				`OFS_RESP_DATA: begin
					next_st.pslverr = apbReq.pwrite;
					if (st.respPtr < st.respLen) begin
						next_st.prdata[15:0] = respWord;
					end
				end
				`OFS_MODE: begin
					next_st.pslverr = apbReq.pwrite;
					next_st.prdata[`MODE_CFGSEL_BIT] = st.desired.configModeSel;
					next_st.prdata[`MODE_AUTOADDR_BIT] = st.desired.autoAddrEn;
				end
				default: begin
					next_st.pslverr = 1'b1;
				end
			endcase
		end

		if (access && !st.pslverr) begin
			if (apbReq.pwrite && (apbReq.paddr == `OFS_JOB_DATA) && !st.busy) begin
				// overflow saturates, so an over-long job fails the length check
				if (st.jobWordCount != `JOB_CNT_MAX) begin
					next_st.jobWordCount = st.jobWordCount + 5'd1;
				end
			end
			if (apbReq.pwrite && (apbReq.paddr == `OFS_JOB_CTRL) && !st.busy) begin
				if (apbReq.pwdata[`CTRL_CLEAR_BIT]) begin
					next_st.jobWordCount = '0;
					next_st.respLen = '0;
					next_st.respPtr = '0;
					next_st.done = 1'b0;
					next_st.error = 1'b0;
				end else if (apbReq.pwdata[`CTRL_START_BIT]) begin
					next_st.done = 1'b0;
					next_st.error = 1'b0;
					next_st.jobWordCount = '0;
					if (st.jobWordCount != '0 && jobWord[15:12] == `CMD_GROUP
						&& jobWord[11:8] == `CMD_READ_TOTAL && st.jobWordCount == `READ_JOB_LEN) begin
						next_st.respLen = `RESP_LEN;
						next_st.respPtr = '0;
						next_st.done = 1'b1;
					end else if (st.jobWordCount != '0 && jobWord[15:12] == `CMD_GROUP
						&& jobWord[11:8] == `CMD_CONFIG_TOTAL && st.jobWordCount == `CONFIG_JOB_LEN) begin
						next_st.fsm = total_config_pkg::ST_LOAD;
						next_st.busy = 1'b1;
						next_st.loadIdx = `JOB_LIST_FIRST;
						next_st.respLen = '0;
						next_st.respPtr = '0;
					end else begin
						next_st.error = 1'b1;
					end
				end
			end
			if (!apbReq.pwrite && (apbReq.paddr == `OFS_RESP_DATA) && (st.respPtr < st.respLen)) begin
				next_st.respPtr = st.respPtr + 5'd1;
			end
		end

		// ----------------------------------------------------------------
		// configure job: one job word per cycle into the desired set
		// ----------------------------------------------------------------
		unique case (st.fsm)
			total_config_pkg::ST_IDLE: begin
			end
			total_config_pkg::ST_LOAD: begin
				if (st.loadIdx < `JOB_CFG_FIRST) begin
					w = int'(st.loadIdx - `JOB_LIST_FIRST);
					for (int k = 0; k < 16; k++) begin
						next_st.desired.projectedSlaveList[16*w+k] = jobWord[15-k];
					end
				end else if (st.loadIdx < `JOB_PARAM_FIRST) begin
					s = 2 * int'(st.loadIdx - `JOB_CFG_FIRST);
					next_st.desired.slaveCfg[8*s +: 8] = jobWord[15:8];
					next_st.desired.slaveCfg[8*(s+1) +: 8] = jobWord[7:0];
				end else if (st.loadIdx < `JOB_FLAG_WORD) begin
					for (int n = 0; n < 4; n++) begin
						s = 4 * int'(st.loadIdx - `JOB_PARAM_FIRST) + n;
						if (s != 0) begin
							next_st.desired.slaveParam[4*s +: 4] = jobWord[15-4*n -: 4];
						end
					end
				end else begin
					// only the two mode flags are taken
					next_st.desired.configModeSel = jobWord[`FLAGW_CFG_MODE_BIT];
					next_st.desired.autoAddrEn = jobWord[`FLAGW_AUTO_ADDR_BIT];
				end
				if (st.loadIdx == `JOB_FLAG_WORD) begin
					next_st.fsm = total_config_pkg::ST_IDLE;
					next_st.busy = 1'b0;
					next_st.done = 1'b1;
					next_st.nvStore = 1'b1;
				end else begin
					next_st.loadIdx = st.loadIdx + 5'd1;
				end
			end
		endcase

		// start-up after synchronisation takes the stored mode and resends parameters
		if (syncDone) begin
			next_st.configMode = st.desired.configModeSel;
			next_st.paramSend = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
			st.fsm <= total_config_pkg::ST_IDLE;
			st.configMode <= `RST_CONFIG_MODE;
			st.desired.configModeSel <= `RST_CFG_MODE_SEL;
			st.desired.autoAddrEn <= `RST_AUTO_ADDR;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign apbRsp.pready = 1'b1;
	assign apbRsp.prdata = st.prdata;
	assign apbRsp.pslverr = st.pslverr & access;
	assign desired = st.desired;
	assign configModeActive = st.configMode;
	// configuration mode lets every detected slave run; protected mode gates by the projected list
	assign activateMask = st.configMode ? actual.detectedList : st.desired.projectedSlaveList;
	assign nvStore = st.nvStore;
	assign paramSend = st.paramSend;

endmodule : total_config_job_handler

// File: tb/total_config_job_handler_props.sv
// Purpose: port checks of the total-configuration job handler
// Assumes: one clock, zero-wait register bus
// Notes: bound to every instance of the handler
`timescale 1ns/1ps
module total_config_job_handler_props (
	input wire logic sys_clk,
	input wire logic nrst,
	input total_config_pkg::apb_req_t apbReq,
	input total_config_pkg::apb_rsp_t apbRsp,
	input total_config_pkg::actual_cfg_t actual,
	input wire logic syncDone,
	input total_config_pkg::desired_cfg_t desired,
	input wire logic configModeActive,
	input wire logic [31:0] activateMask,
	input wire logic nvStore,
	input wire logic paramSend
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_prot; !configModeActive |-> activateMask == desired.projectedSlaveList; endproperty
	a_prot: assert property (p_prot) else $error("protected mask wrong");
	property p_cfgmask; configModeActive |-> activateMask == actual.detectedList; endproperty
	a_cfgmask: assert property (p_cfgmask) else $error("config mode mask wrong");
	property p_send; syncDone |=> paramSend ##1 !paramSend; endproperty
	a_send: assert property (p_send) else $error("parameter send pulse wrong");
	property p_sendcause; paramSend |-> $past(syncDone); endproperty
	a_sendcause: assert property (p_sendcause) else $error("parameter send without sync");
	property p_nvone; nvStore |=> !nvStore; endproperty
	a_nvone: assert property (p_nvone) else $error("store pulse too long");
	property p_mode; syncDone |=> configModeActive == $past(desired.configModeSel); endproperty
	a_mode: assert property (p_mode) else $error("mode after sync wrong");
	// the mode may only move at start-up, never on a job
	property p_modehold; !$stable(configModeActive) |-> $past(syncDone); endproperty
	a_modehold: assert property (p_modehold) else $error("mode changed without sync");
	property p_err; apbReq.psel && apbReq.penable && apbReq.paddr == 8'h14 |-> apbRsp.pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_errgate; apbRsp.pslverr |-> apbReq.psel && apbReq.penable; endproperty
	a_errgate: assert property (p_errgate) else $error("error outside access");
	c_store: cover property (nvStore);
	c_prot: cover property (paramSend && !configModeActive);
	c_err: cover property (apbRsp.pslverr);
endmodule : total_config_job_handler_props

bind total_config_job_handler total_config_job_handler_props u_props (.sys_clk(sys_clk), .nrst(nrst),
	.apbReq(apbReq), .apbRsp(apbRsp), .actual(actual), .syncDone(syncDone), .desired(desired),
	.configModeActive(configModeActive), .activateMask(activateMask), .nvStore(nvStore), .paramSend(paramSend));

// File: tb/bus_view_model.sv
// Purpose: stands in for the bus sequencer that feeds the live bus view
// Assumes: a new view only when asked, sync pulse one cycle after request
// Notes: the view holds still between requests so responses are predictable
`timescale 1ns/1ps
module bus_view_model (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic newView,
	input wire logic [31:0] seed,
	input wire logic syncReq,
	output total_config_pkg::actual_cfg_t actual,
	output logic syncDone
);
	// ----------------------------------------------------------------
	// view generation
	// ----------------------------------------------------------------
	function automatic logic [455:0] spread(input logic [31:0] s);
		logic [479:0] v;
		for (int i = 0; i < 15; i++) begin
			v[32*i+:32] = s;
			s = s * 32'h9e3779b1 + 32'h7f4a7c15;
		end
		return v[455:0];
	endfunction : spread
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			actual <= '0;
			syncDone <= 1'b0;
		end else begin
			syncDone <= syncReq;
			if (newView) begin
				actual <= total_config_pkg::actual_cfg_t'(spread(seed));
			end
		end
	end
endmodule : bus_view_model

// File: tb/total_config_job_handler_test.sv
// Purpose: self-checking bench of the total-configuration job handler
// Assumes: zero-wait register bus, partner model drives the bus view
// Notes: expected words are rebuilt from the bus view and the jobs sent
`timescale 1ns/1ps
`include "total_config_consts.svh"
module total_config_job_handler_test;
	logic sys_clk, nrst, syncDone, configModeActive, nvStore, paramSend, newView, syncReq, e, eSel, eAuto, eMode, m;
	logic [31:0] activateMask, rs, r, lst, ePrj;
	logic [255:0] eCfg, rc;
	logic [127:0] ePar, rp;
	logic [15:0] wd [0:27];
	total_config_pkg::apb_req_t apbReq;
	total_config_pkg::apb_rsp_t apbRsp;
	total_config_pkg::actual_cfg_t actual;
	total_config_pkg::desired_cfg_t desired;
	int bad_count, checked, nvCnt, psCnt;
	total_config_job_handler u_dut (.sys_clk(sys_clk), .nrst(nrst), .apbReq(apbReq), .apbRsp(apbRsp),
		.actual(actual), .syncDone(syncDone), .desired(desired), .configModeActive(configModeActive),
		.activateMask(activateMask), .nvStore(nvStore), .paramSend(paramSend));
	bus_view_model u_bus (.sys_clk(sys_clk), .nrst(nrst), .newView(newView), .seed(rs), .syncReq(syncReq),
		.actual(actual), .syncDone(syncDone));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (nvStore === 1'b1) nvCnt++;
		if (paramSend === 1'b1) psCnt++;
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] nx(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : nx
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic err);
		apbReq.psel <= 1'b1;
		apbReq.pwrite <= w;
		apbReq.paddr <= a;
		apbReq.pwdata <= d;
		apbReq.penable <= 1'b0;
		@(posedge sys_clk);
		apbReq.penable <= 1'b1;
		// no cycle limit here: only the watchdog ends a wait for pready
		do begin
			@(posedge sys_clk);
		end while (apbRsp.pready !== 1'b1);
		q = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	task automatic job(input int n);
		apb(1'b1, `OFS_JOB_CTRL, 32'h2, r, e);
		for (int i = 0; i < n; i++) apb(1'b1, `OFS_JOB_DATA, {16'h0, wd[i]}, r, e);
		apb(1'b1, `OFS_JOB_CTRL, 32'h1, r, e);
		for (int i = 0; i < 60; i++) begin
			apb(1'b0, `OFS_STATUS, 32'h0, r, e);
			if (r[0] === 1'b0) break;
		end
		// a poll limit that runs out counts as a mismatch
		chk("busy cleared", 32'h0, {31'h0, r[0]});
	endtask : job
	// same packing serves the read response and the configure job
	task automatic fill(input logic [31:0] l, input logic [255:0] c, input logic [127:0] p);
		for (int i = 0; i < 16; i++) begin
			wd[1][15-i] = l[i];
			wd[2][15-i] = l[16+i];
			wd[3+i] = {c[16*i+:8], c[16*i+8+:8]};
		end
		for (int s = 0; s < 32; s++) wd[19+s/4][12-4*(s%4)+:4] = (s == 0) ? 4'h0 : p[4*s+:4];
	endtask : fill
	task automatic rdjob();
		rs = nx(rs);
		wd[0] = {8'h19, rs[7:0]};
		job(1);
		chk("read status", {11'h0, 5'd27, 12'h0, eMode, 3'b010}, r & 32'h1f1f0f);
		m = (ePrj === actual.detectedList);
		for (int s = 0; s < 32; s++) if (ePrj[s] && eCfg[8*s+:8] !== actual.slaveCfg[8*s+:8]) m = 1'b0;
		fill(actual.activeSlaveList, actual.slaveCfg, actual.slaveParam);
		wd[27] = {m, actual.zeroAddressPresent, eAuto & actual.noWrongSlave, actual.autoprogPossible, eMode,
			actual.normalMode, actual.lowBusVoltage, actual.offlineActive, 4'h0, eAuto, actual.eepromOk, 1'b0,
			actual.offlineRequested};
		for (int i = 0; i < 27; i++) begin
			apb(1'b0, `OFS_RESP_DATA, 32'h0, r, e);
			chk("response word", {16'h0, wd[i+1]}, r);
		end
	endtask : rdjob
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		apbReq = '0;
		newView = 1'b0;
		syncReq = 1'b0;
		rs = 32'h42c1;
		{bad_count, checked, nvCnt, psCnt} = '0;
		{ePrj, eCfg, ePar, eAuto} = '0;
		{eSel, eMode} = 2'b11;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		apb(1'b0, `OFS_MODE, 32'h0, r, e);
		chk("mode after reset", 32'h1, r);
		apb(1'b0, 8'h14, 32'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		for (int k = 0; k < 3; k++) begin
			rs = nx(rs);
			newView <= 1'b1;
			@(posedge sys_clk);
			newView <= 1'b0;
			@(posedge sys_clk);
			for (int i = 0; i < 8; i++) begin
				rs = nx(rs);
				rc[32*i+:32] = rs;
			end
			for (int i = 0; i < 4; i++) begin
				rs = nx(rs);
				rp[32*i+:32] = rs;
			end
			lst = (k == 1) ? actual.detectedList : nx(rs);
			if (k == 1) rc = actual.slaveCfg;
			fill(lst, rc, rp);
			rs = nx(rs);
			wd[0] = {8'h1a, rs[7:0]};
			wd[27] = {rs[15:12], k[0], rs[10:0]};
			job((k == 2) ? 27 : 28);
			if (k < 2) {ePrj, eCfg, ePar, eSel, eAuto} = {lst, rc, rp, k[0], rs[3]};
			chk("config error", 32'(k == 2), {31'h0, r[2]});
			chk("store pulses", 32'((k == 2) ? 2 : k + 1), 32'(nvCnt));
			chk("projected list", ePrj, desired.projectedSlaveList);
			chk("config bytes", 32'h0, 32'(eCfg !== desired.slaveCfg));
			chk("parameters", 32'h0, 32'(ePar[127:4] !== desired.slaveParam[127:4]));
			apb(1'b0, `OFS_MODE, 32'h0, r, e);
			chk("mode register", {30'h0, eAuto, eSel}, r);
			if (k == 2) begin
				wd[0] = 16'h1b00;
				job(1);
				chk("bad command error", 32'h1, {31'h0, r[2]});
			end
			syncReq <= 1'b1;
			@(posedge sys_clk);
			syncReq <= 1'b0;
			repeat (3) @(posedge sys_clk);
			eMode = eSel;
			chk("mode after sync", {31'h0, eSel}, {31'h0, configModeActive});
			chk("activation mask", eSel ? actual.detectedList : ePrj, activateMask);
			chk("parameter sends", 32'(k + 1), 32'(psCnt));
			rdjob();
			$display("test %0d done", k);
		end
		test_done();
	end
	initial begin
		#100us;
		bad_count++;
		$display("watchdog expired");
		test_done();
	end
endmodule : total_config_job_handler_test
